/* File: hdl/flash_cmd.sv */
// Purpose: command sequencer of a serial NOR flash on single, dual or quad SPI pins
// Assumes: array answers a read one cycle after mem_req.rd; pins are asynchronous to clk_sys
// Notes: the SPI clock is sampled by clk_sys, so it must stay well below a quarter of 20 MHz
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs.svh"

// small first-in first-out buffer between array reads and the output shifter
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t r, n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // wrap a pointer at the depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : step

  // handshake terms
  assign in_ready = (r.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = mem[r.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    n = r;
    if (push) n.wr = step(r.wr);
    if (pop) n.rd = step(r.rd);
    n.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    if (flush) n = '0;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) r <= '0;
    else r <= n;
  end

  // storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) mem[r.wr] <= in_data;
  end
endmodule : byte_fifo

module flash_cmd
#(
  parameter int unsigned WSR_CYCLES = `WSR_TIME_NS / `SYS_PERIOD_NS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // flash pins, io lines split into input, output and enable
  input wire flash_pkg::spi_pins_t pins_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // array read port
  output flash_pkg::mem_req_t mem_req,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rdata,
  // program and erase engine outside
  input wire logic ext_busy,
  input wire logic ext_done,
  // status word
  output logic [15:0] status
);
  import flash_pkg::*;

  // pins idle at their deselected level so no false chip-select edge follows reset
  localparam spi_pins_t PINS_IDLE = '{cs_n: 1'b1, default: '0};
  localparam seq_t SEQ_RST = '{sync1: PINS_IDLE, sync2: PINS_IDLE, cs_d: 1'b1,
                               status: `STAT_RESET, state: ST_IDLE, default: '0};

  seq_t r, n;
  logic rise, fall, cs_fall, cs_rise;
  logic [7:0] op;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_data;
  logic [7:0] ld;
  logic [5:0] cnt_next;

  // shift lane bits into a word, line 3 or 1 carrying the higher bit
  function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] io,
                                           input logic [2:0] lanes);
    case (lanes)
      3'd4: shift_in = {v[19:0], io};
      3'd2: shift_in = {v[21:0], io[1:0]};
      default: shift_in = {v[22:0], io[0]};
    endcase
  endfunction : shift_in
  // place the top bits of a byte on the lines
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] lanes);
    case (lanes)
      3'd4: lane_bits = b[7:4];
      3'd2: lane_bits = {2'b00, b[7:6]};
      default: lane_bits = {2'b00, b[7], 1'b0};
    endcase
  endfunction : lane_bits
  // lines driven for each width
  function automatic logic [3:0] lane_mask(input logic [2:0] lanes);
    case (lanes)
      3'd4: lane_mask = 4'hF;
      3'd2: lane_mask = 4'h3;
      default: lane_mask = 4'h2;
    endcase
  endfunction : lane_mask
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(cs_rise),
    .in_valid(mem_rd_valid & r.pend),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // edges of the synchronised pins; second stage against its delayed copy
  assign rise = r.sync2.sck & ~r.sck_d & ~r.sync2.cs_n;
  assign fall = ~r.sync2.sck & r.sck_d & ~r.sync2.cs_n;
  assign cs_fall = ~r.sync2.cs_n & r.cs_d;
  assign cs_rise = r.sync2.cs_n & ~r.cs_d;
  assign op = {r.opc[6:0], r.sync2.io[0]};
  assign cnt_next = r.cnt + {3'b000, r.ilanes};

  // next-state logic of the whole sequencer
  always_comb begin
    n = r;
    fifo_pop = 1'b0;
    ld = r.obyte;
    n.mem.rd = 1'b0;
    n.sync1 = pins_in;
    n.sync2 = r.sync1;
    n.sck_d = r.sync2.sck;
    n.cs_d = r.sync2.cs_n;
    // self-timed status write cycle
    if (r.wsr_busy) begin
      if (r.timer == '0) begin
        n.wsr_busy = 1'b0;
        n.status[`BIT_WRITE_LATCH] = 1'b0;
      end else begin
        n.timer = r.timer - 32'd1;
      end
    end
    if (ext_done) n.status[`BIT_WRITE_LATCH] = 1'b0;
    // new frame: opcode, or straight to address in continuous read
    if (cs_fall) begin
      n.cnt = '0;
      n.obits = '0;
      n.io_oe = '0;
      if (r.crm) begin
        n.state = ST_ADDR;
        n.opc = r.crm_quad ? `OP_RD_QUAD_IO : `OP_RD_DUAL_IO;
        n.ilanes = r.crm_quad ? 3'd4 : 3'd2;
        n.olanes = n.ilanes;
      end else begin
        n.state = ST_OPCODE;
        n.ilanes = 3'd1;
      end
    end
    // input sampling on rising sck
    if (rise) begin
      case (r.state)
        ST_OPCODE: begin
          n.opc = op;
          n.cnt = r.cnt + 6'd1;
          if (r.cnt == 6'd7) begin
            n.cnt = '0;
            n.state = ST_IDLE;
            case (op)
              `OP_LATCH_SET, `OP_LATCH_CLR: if (!r.status[`BIT_BUSY]) n.state = ST_END;
              `OP_STAT1_RD, `OP_STAT2_RD: begin
                n.state = ST_STAT;
                n.stat_hi = (op == `OP_STAT2_RD);
                n.olanes = 3'd1;
              end
              `OP_STAT_WR: begin
                if (r.status[`BIT_WRITE_LATCH] && !r.status[`BIT_BUSY]) n.state = ST_WSR;
              end
              `OP_RD_PLAIN, `OP_RD_FAST: begin
                if (!r.status[`BIT_BUSY]) n.state = ST_ADDR;
                n.olanes = 3'd1;
              end
              `OP_RD_DUAL_OUT: begin
                if (!r.status[`BIT_BUSY]) n.state = ST_ADDR;
                n.olanes = 3'd2;
              end
              `OP_RD_QUAD_OUT: begin
                if (!r.status[`BIT_BUSY] && r.status[`BIT_QUAD_ENABLE]) n.state = ST_ADDR;
                n.olanes = 3'd4;
              end
              `OP_RD_DUAL_IO: begin
                if (!r.status[`BIT_BUSY]) n.state = ST_ADDR;
                n.ilanes = 3'd2;
                n.olanes = 3'd2;
              end
              `OP_RD_QUAD_IO: begin
                if (!r.status[`BIT_BUSY] && r.status[`BIT_QUAD_ENABLE]) n.state = ST_ADDR;
                n.ilanes = 3'd4;
                n.olanes = 3'd4;
              end
              default: n.state = ST_IDLE;
            endcase
          end
        end
        ST_ADDR: begin
          n.addr = shift_in(r.addr, r.sync2.io, r.ilanes);
          n.cnt = cnt_next;
          if (cnt_next == `ADDR_BITS) begin
            n.cnt = '0;
            n.fetch = 1'b1;
            case (r.opc)
              `OP_RD_PLAIN: n.state = ST_DATA;
              `OP_RD_DUAL_IO, `OP_RD_QUAD_IO: n.state = ST_MODE;
              default: n.state = ST_DUMMY;
            endcase
          end
        end
        ST_MODE: begin
          n.mode = 8'(shift_in({16'h0000, r.mode}, r.sync2.io, r.ilanes));
          n.cnt = cnt_next;
          if (cnt_next == `MODE_BITS) begin
            n.cnt = '0;
            n.crm = (n.mode[7:4] == `CRM_NIBBLE);
            n.crm_quad = (r.opc == `OP_RD_QUAD_IO);
            n.state = (r.opc == `OP_RD_QUAD_IO) ? ST_DUMMY : ST_DATA;
          end
        end
        ST_DUMMY: begin
          n.cnt = r.cnt + 6'd1;
          if (n.cnt == ((r.opc == `OP_RD_QUAD_IO) ? `QIO_DUMMY_CLKS : `FAST_DUMMY_CLKS)) begin
            n.cnt = '0;
            n.state = ST_DATA;
          end
        end
        ST_WSR: begin
          n.wdata = {r.wdata[14:0], r.sync2.io[0]};
          if (r.cnt != 6'h3F) n.cnt = r.cnt + 6'd1;
        end
        ST_END: n.state = ST_IDLE;
        ST_DATA, ST_STAT, ST_IDLE: n.cnt = r.cnt;
        default: n.state = ST_IDLE;
      endcase
    end
    // output shifting on falling sck, a fresh byte when the last one is spent
    if (fall && (r.state == ST_DATA || r.state == ST_STAT)) begin
      if (r.obits == '0) begin
        if (r.state == ST_STAT) begin
          ld = r.stat_hi ? r.status[15:8] : r.status[7:0];
        end else begin
          ld = fifo_out_valid ? fifo_data : 8'hFF;
          fifo_pop = fifo_out_valid;
        end
        n.obits = `DATA_BITS - {1'b0, r.olanes};
      end else begin
        n.obits = r.obits - {1'b0, r.olanes};
      end
      n.io_out = lane_bits(ld, r.olanes);
      n.io_oe = lane_mask(r.olanes);
      n.obyte = ld << r.olanes;
    end
    // prefetch of consecutive bytes while the buffer has room
    if (r.fetch && fifo_in_ready && !r.pend) begin
      n.mem.rd = 1'b1;
      n.mem.addr = r.addr;
      n.addr = r.addr + 24'd1;
      n.pend = 1'b1;
    end
    if (mem_rd_valid) n.pend = 1'b0;
    // end of frame: latch commands and status write take effect here
    if (cs_rise) begin
      case (r.state)
        ST_END: begin
          if (r.opc == `OP_LATCH_SET) n.status[`BIT_WRITE_LATCH] = 1'b1;
          else n.status[`BIT_WRITE_LATCH] = 1'b0;
        end
        ST_WSR: begin
          if (r.cnt == 6'd8) begin
            n.status[7:2] = r.wdata[7:2];
            n.status[`BIT_QUAD_ENABLE] = 1'b0;
            n.status[`BIT_STATUS_LOCK_1] = 1'b0;
          end else if (r.cnt == 6'd16) begin
            n.status[7:2] = r.wdata[15:10];
            n.status[`BIT_QUAD_ENABLE] = r.wdata[1];
            n.status[`BIT_STATUS_LOCK_1] = r.wdata[0];
          end
          if (r.cnt == 6'd8 || r.cnt == 6'd16) begin
            n.wsr_busy = 1'b1;
            n.timer = 32'(WSR_CYCLES - 1);
          end
        end
        default: n.cnt = '0;
      endcase
      n.state = ST_IDLE;
      n.fetch = 1'b0;
      n.pend = 1'b0;
      n.io_oe = '0;
      n.obits = '0;
    end
    n.status[`BIT_BUSY] = n.wsr_busy | ext_busy;
  end
  // single register stage for all state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) r <= SEQ_RST;
    else r <= n;
  end

  // outputs straight from the state register
  assign io_out = r.io_out;
  assign io_oe = r.io_oe;
  assign mem_req = r.mem;
  assign status = r.status;
endmodule : flash_cmd
`default_nettype wire

/* File: hdl/flash_pkg.sv */
// Purpose: types shared by the flash command sequencer
// Assumes: flash_regs.svh holds the numbers
// Notes: state field sits in the low bits of seq_t so its reset pattern is easy to build
package flash_pkg;
  typedef enum logic [8:0] {
    ST_OPCODE = 9'h001,
    ST_ADDR = 9'h002,
    ST_MODE = 9'h004,
    ST_DUMMY = 9'h008,
    ST_DATA = 9'h010,
    ST_STAT = 9'h020,
    ST_WSR = 9'h040,
    ST_END = 9'h080,
    ST_IDLE = 9'h100
  } seq_state_t;

  // flash pins as seen from inside
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } spi_pins_t;

  // array read request
  typedef struct packed {
    logic rd;
    logic [23:0] addr;
  } mem_req_t;

  // whole sequencer state
  typedef struct packed {
    spi_pins_t sync1;
    spi_pins_t sync2;
    logic sck_d;
    logic cs_d;
    logic [5:0] cnt;
    logic [7:0] opc;
    logic [2:0] ilanes;
    logic [2:0] olanes;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [15:0] wdata;
    logic [7:0] obyte;
    logic [3:0] obits;
    logic stat_hi;
    logic crm;
    logic crm_quad;
    logic [15:0] status;
    logic wsr_busy;
    logic [31:0] timer;
    logic fetch;
    logic pend;
    mem_req_t mem;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    seq_state_t state;
  } seq_t;
endpackage : flash_pkg

/* File: hdl/flash_regs.svh */
// Purpose: opcodes, status bit positions and timing figures of the flash command sequencer
// Assumes: included by its bare name from the design file
// Notes: definitions only
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH
// opcodes
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLR 8'h04
`define OP_STAT1_RD 8'h05
`define OP_STAT2_RD 8'h35
`define OP_STAT_WR 8'h01
`define OP_RD_PLAIN 8'h03
`define OP_RD_FAST 8'h0B
`define OP_RD_DUAL_OUT 8'h3B
`define OP_RD_QUAD_OUT 8'h6B
`define OP_RD_DUAL_IO 8'hBB
`define OP_RD_QUAD_IO 8'hEB
// status bit positions and reset value
`define BIT_BUSY 0
`define BIT_WRITE_LATCH 1
`define BIT_STATUS_LOCK_1 8
`define BIT_QUAD_ENABLE 9
`define STAT_RESET 16'h0000
// phase lengths in bits or clocks, and the mode nibble that selects continuous read
`define ADDR_BITS 6'h18
`define MODE_BITS 6'h08
`define DATA_BITS 4'h8
`define FAST_DUMMY_CLKS 6'h08
`define QIO_DUMMY_CLKS 6'h04
`define CRM_NIBBLE 4'hA
// self-timed status write, system clock and buffer depth
`define WSR_TIME_NS 10000000
`define SYS_PERIOD_NS 50
`define FIFO_DEPTH 4
`endif

/* File: sim/flash_cmd_sva.sv */
// Purpose: port-level checks of the flash command sequencer
// Assumes: ext_busy stays low, so busy comes only from status writes
// Notes: bound to every flash_cmd instance
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_sva
  import flash_pkg::*;
#(
  parameter int unsigned WSR_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // flash pins
  input wire flash_pkg::spi_pins_t pins_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // array port and engine
  input wire flash_pkg::mem_req_t mem_req,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rdata,
  input wire logic ext_busy,
  input wire logic ext_done,
  // status word
  input wire logic [15:0] status
);
  logic [31:0] busy_cnt_r;
  logic [23:0] last_addr_r;
  logic gap_r;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // busy stretch length, last array address, deselect seen since last read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= '0;
      last_addr_r <= '0;
      gap_r <= 1'b1;
    end else begin
      busy_cnt_r <= status[0] ? busy_cnt_r + 32'h1 : 32'h0;
      if (mem_req.rd) last_addr_r <= mem_req.addr;
      gap_r <= pins_in.cs_n | (gap_r & !mem_req.rd);
    end
  end

  AST_OE_IDLE: assert property (pins_in.cs_n [*5] |-> io_oe == 4'h0)
    else $error("io lines driven while deselected");
  AST_RD_PULSE: assert property (mem_req.rd |=> !mem_req.rd && $stable(mem_req.addr))
    else $error("array read not a single pulse");
  AST_ADDR_STEP: assert property (mem_req.rd && !gap_r |-> mem_req.addr == last_addr_r + 24'h1)
    else $error("array address did not step by one");
  AST_BUSY_LEN: assert property ($fell(status[0]) |-> busy_cnt_r >= WSR_CYCLES - 2 && busy_cnt_r <= WSR_CYCLES + 3)
    else $error("busy stretch has wrong length");
  AST_LATCH_END: assert property ($fell(status[0]) |-> ##[0:2] !status[1])
    else $error("write latch kept after busy end");
  AST_DONE_CLR: assert property (ext_done && pins_in.cs_n && $past(pins_in.cs_n, 5) |-> ##[1:2] !status[1])
    else $error("write latch kept after engine done");
  AST_BUSY_NO_RD: assert property (status[0] && !ext_busy |-> !mem_req.rd)
    else $error("array read during busy");
  AST_LANE_SET: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal output lane set");
  AST_LATCH_SET: assert property ($rose(status[1]) |-> pins_in.cs_n && $past(pins_in.cs_n, 2))
    else $error("write latch set before deselect");
  AST_BUSY_START: assert property ($rose(status[0]) && !ext_busy |-> pins_in.cs_n)
    else $error("busy started inside a frame");

  // main scenarios
  cover property ($fell(status[0]));
  cover property (io_oe == 4'hF);
  cover property (mem_req.rd && !gap_r);
endmodule : flash_cmd_sva

bind flash_cmd flash_cmd_sva #(.WSR_CYCLES(WSR_CYCLES)) sva_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .pins_in(pins_in), .io_out(io_out), .io_oe(io_oe), .mem_req(mem_req),
  .mem_rd_valid(mem_rd_valid), .mem_rdata(mem_rdata), .ext_busy(ext_busy),
  .ext_done(ext_done), .status(status));
`default_nettype wire

/* File: sim/flash_cmd_tb_top.sv */
// Purpose: self-checking bench of the flash command sequencer
// Assumes: host model on the pins, behavioural array answering reads
// Notes: the self-timed status write is shortened to WSR_N cycles
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_tb_top;
  import flash_pkg::*;
  localparam int unsigned WSR_N = 600;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ext_busy = 1'b0;
  logic ext_done = 1'b0;
  logic mem_rd_valid = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  spi_pins_t pins_in;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  mem_req_t mem_req;
  logic [15:0] status;
  logic [7:0] rx_byte;
  logic [15:0] e;
  int rx_cnt;
  int fails = 0;
  int tests_run = 0;
  int rd_cnt = 0;
  logic [15:0] exp_q[$];
  logic [7:0] ops[6] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
  int al[7] = '{1, 1, 1, 1, 2, 4, 4};
  int dm[7] = '{0, 8, 8, 8, 0, 4, 4};
  int dl[7] = '{1, 1, 2, 4, 2, 4, 4};
  logic [7:0] r;
  int n;

  always #25 clk_sys = ~clk_sys;

  flash_cmd #(.WSR_CYCLES(WSR_N)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .pins_in(pins_in),
    .io_out(io_out), .io_oe(io_oe), .mem_req(mem_req), .mem_rd_valid(mem_rd_valid),
    .mem_rdata(mem_rdata), .ext_busy(ext_busy), .ext_done(ext_done), .status(status));
  spi_host host (.io_out(io_out), .io_oe(io_oe), .pins(pins_in), .rx_byte(rx_byte),
    .rx_cnt(rx_cnt));

  function automatic logic [7:0] arr(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction : arr

  // array stand-in answers one cycle after each request
  always @(posedge clk_sys) begin
    mem_rd_valid <= mem_req.rd;
    mem_rdata <= arr(mem_req.addr);
    if (mem_req.rd === 1'b1) rd_cnt <= rd_cnt + 1;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // oldest note against each byte the host received; none left is a mismatch
  always @(rx_cnt) begin
    #1;
    e = exp_q.size() != 0 ? exp_q.pop_front() : {8'hFF, ~rx_byte};
    chk(rx_byte & e[15:8], e[7:0] & e[15:8]);
  end

  task automatic cmd(input logic [31:0] v, input int bits);
    host.start();
    host.send(v, bits, 1);
    host.stop();
  endtask : cmd

  task automatic st_rd(input logic [7:0] opc, input logic [7:0] m, input logic [7:0] x, input int k);
    repeat (k) exp_q.push_back({m, x});
    host.start();
    host.send({24'h000000, opc}, 8, 1);
    host.recv(k, 1);
    host.stop();
  endtask : st_rd

  // read mode m: 03 0B 3B 6B BB EB, 6 = EB without opcode
  task automatic rd(input int m, input logic [23:0] a, input logic [7:0] c);
    for (int i = 0; i < 3; i++) exp_q.push_back({8'hFF, arr(a + 24'(i))});
    host.start();
    if (m != 6) host.send({24'h000000, ops[m]}, 8, 1);
    host.send(m >= 4 ? {a, c} : {8'h00, a}, m >= 4 ? 32 : 24, al[m]);
    host.idle(dm[m]);
    host.recv(3, dl[m]);
    host.stop();
  endtask : rd

  task automatic wait_idle();
    int k;
    k = 0;
    while (status[0] !== 1'b0 && k < 2000) begin
      @(posedge clk_sys);
      #2 k++;
    end
    if (status[0] !== 1'b0) begin
      fails++;
      give_verdict();
    end
  endtask : wait_idle

  // main sequence
  initial begin
    n = $urandom(32'h8A02DAD6);
    repeat (6) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #2;
    st_rd(8'h05, 8'hFF, 8'h00, 2);
    st_rd(8'h35, 8'hFF, 8'h00, 1);
    cmd({8'h01, 8'hFC}, 16);
    st_rd(8'h05, 8'hFF, 8'h00, 1);
    cmd(32'h06, 8);
    st_rd(8'h05, 8'hFF, 8'h02, 1);
    cmd(32'h04, 8);
    st_rd(8'h05, 8'hFF, 8'h00, 1);
    cmd(32'h06, 8);
    @(posedge clk_sys);
    #2 ext_done = 1'b1;
    @(posedge clk_sys);
    #2 ext_done = 1'b0;
    st_rd(8'h05, 8'hFF, 8'h00, 1);
    r = 8'($urandom) & 8'h7F;
    cmd(32'h06, 8);
    cmd({8'h01, r, 8'h02}, 24);
    n = rd_cnt;
    cmd({8'h03, 16'h0000, r}, 32);
    chk(8'(rd_cnt), 8'(n));
    st_rd(8'h05, 8'h01, 8'h01, 1);
    wait_idle();
    chk(status[7:0], r & 8'hFC);
    st_rd(8'h05, 8'hFF, r & 8'hFC, 1);
    st_rd(8'h35, 8'hFF, 8'h02, 1);
    cmd(32'h06, 8);
    cmd({8'h01, 12'h0F0}, 20);
    st_rd(8'h05, 8'hFF, (r & 8'hFC) | 8'h02, 1);
    for (int m = 0; m < 7; m++) begin
      rd(m, m == 0 ? 24'hFFFFFE : 24'($urandom), m == 5 ? 8'hA5 : 8'h00);
    end
    cmd({8'h01, 8'h00}, 16);
    wait_idle();
    st_rd(8'h35, 8'hFF, 8'h00, 1);
    st_rd(8'h05, 8'hFF, 8'h00, 1);
    n = rd_cnt;
    cmd({8'h6B, 24'h000100}, 32);
    cmd({8'hC3, 24'h000100}, 32);
    chk(8'(rd_cnt), 8'(n));
    give_verdict();
  end
endmodule : flash_cmd_tb_top
`default_nettype wire

/* File: sim/spi_host.sv */
// Purpose: host controller model driving the flash pins in mode 0
// Assumes: tasks are entered 2 ns after a clk_sys rising edge
// Notes: a released line toggles each clock so stale bits never pass
`timescale 1ns/1ps
`default_nettype none
module spi_host
  import flash_pkg::*;
(
  // device lines
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // resolved pins and received bytes
  output flash_pkg::spi_pins_t pins,
  output logic [7:0] rx_byte,
  output int rx_cnt
);
  import flash_pkg::*;
  logic [3:0] drv;
  logic [3:0] en;
  logic noise;
  logic cs_n;
  logic sck;

  // wire level from both parties
  assign pins = {cs_n, sck, (io_oe & io_out) | (~io_oe & en & drv) | (~io_oe & ~en & {4{noise}})};

  // idle pins, clock stands low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    drv = 4'h0;
    en = 4'h0;
    noise = 1'b0;
    rx_byte = 8'h00;
    rx_cnt = 0;
  end

  // one clock: drive after fall, sample just before next fall
  task automatic cyc(input logic [3:0] v, input logic [3:0] e, output logic [3:0] s);
    drv = v;
    en = e;
    #200 sck = 1'b1;
    #200 s = pins.io;
    sck = 1'b0;
    noise = ~noise;
  endtask : cyc

  task automatic start();
    cs_n = 1'b0;
    #200;
  endtask : start

  task automatic stop();
    #200 cs_n = 1'b1;
    #400;
  endtask : stop

  // msb first, l bits per clock, line 3 or 1 highest
  task automatic send(input logic [31:0] v, input int n, input int l);
    logic [3:0] s;
    for (int i = n - l; i >= 0; i -= l) begin
      cyc(l == 4 ? v[i+:4] : l == 2 ? {2'b00, v[i+:2]} : {3'b000, v[i]},
          l == 4 ? 4'hF : l == 2 ? 4'h3 : 4'h1, s);
    end
  endtask : send

  task automatic idle(input int n);
    logic [3:0] s;
    repeat (n) cyc(4'h0, 4'h0, s);
  endtask : idle

  // assemble bytes: single on line 1, dual odd on line 1, quad upper nibble first
  task automatic recv(input int n, input int l);
    logic [3:0] s;
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8 / l; j++) begin
        cyc(4'h0, 4'h0, s);
        b = l == 4 ? {b[3:0], s} : l == 2 ? {b[5:0], s[1:0]} : {b[6:0], s[1]};
      end
      rx_byte = b;
      rx_cnt++;
    end
  endtask : recv
endmodule : spi_host
`default_nettype wire
